/* logic/asc_control.sv */
// top of the converter sequencing control: AXI4-Lite registers, start and
// stop sequencing, result capture, channel decode and interrupt
// assumes the analog front end presents sample_data stable on aclk when done
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"
module asc_control
    import asc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int NUM_INPUTS = 12
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  ext_trigger_pin,
    input  wire logic [7:0]            sample_data,
    output logic                       sample_start,
    output logic                       conversion_busy,
    output logic [NUM_INPUTS-1:0]      analog_input_select,
    output logic                       irq
);

    // ************************************************************
    // storage
    // ************************************************************
    asc_byte_type              mode_reg;
    asc_byte_type              conversion_result_reg;
    logic [`ASC_IRQ_WIDTH-1:0] irq_status_reg;
    logic [`ASC_IRQ_WIDTH-1:0] irq_mask_reg;
    asc_edge_type              trig_edge_reg;
    logic                      aw_full_reg;
    logic                      w_full_reg;
    logic [9:0]                aw_index_reg;
    logic [31:0]               w_data_reg;
    logic [3:0]                w_strb_reg;
    logic                      bvalid_reg;
    logic [1:0]                bresp_reg;
    logic                      rvalid_reg;
    logic [1:0]                rresp_reg;
    logic [31:0]               rdata_reg;
    logic                      sample_start_reg;
    logic [NUM_INPUTS-1:0]     select_reg;

    logic                      do_write;
    logic                      wr_lane0;
    logic                      wr_mapped;
    logic                      rd_take;
    logic [9:0]                rd_index;
    logic                      rd_mapped;
    logic [31:0]               rd_word;
    logic                      sw_start;
    logic                      sw_stop;
    logic                      ext_edge;
    logic                      ext_start;
    logic                      timer_busy;
    logic                      timer_done;
    logic                      trig_rise;
    logic                      trig_fall;
    logic                      code_valid;
    logic [3:0]                input_number;
    logic [`ASC_IRQ_WIDTH-1:0] irq_events;

    // ************************************************************
    // write channel: address and data taken in either order
    // ************************************************************
    // readies drop while a response is pending, one write at a time
    assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
    assign do_write      = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_lane0      = do_write & w_strb_reg[0];

    // the register index lives in the address bits above the byte lanes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg  <= 1'b0;
            aw_index_reg <= 10'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg  <= 1'b1;
            aw_index_reg <= s_axi_awaddr[11:2];
        end else if (do_write) begin
            aw_full_reg  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    // unmapped writes are answered with an error and change nothing
    always_comb begin
        case (aw_index_reg)
            `ASC_IDX_MODE, `ASC_IDX_RESULT, `ASC_IDX_START_STATUS,
            `ASC_IDX_IRQ_STATUS, `ASC_IDX_IRQ_MASK,
            `ASC_IDX_TRIG_CONFIG: wr_mapped = 1'b1;
            default:              wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `ASC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ************************************************************
    // configuration registers
    // ************************************************************
    // reserved mode bits 5 and 4 are held at one and ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= `ASC_MODE_RESET;
        end else if (wr_lane0 && aw_index_reg == `ASC_IDX_MODE) begin
            mode_reg <= (w_data_reg[7:0] & `ASC_MODE_WR_MASK)
                      | (`ASC_MODE_RESET & ~`ASC_MODE_WR_MASK);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg  <= '0;
            trig_edge_reg <= ASC_EDGE_RISING;
        end else if (wr_lane0 && aw_index_reg == `ASC_IDX_IRQ_MASK) begin
            irq_mask_reg  <= w_data_reg[`ASC_IRQ_WIDTH-1:0];
        end else if (wr_lane0 && aw_index_reg == `ASC_IDX_TRIG_CONFIG) begin
            trig_edge_reg <= asc_edge_type'(w_data_reg[`ASC_TRIG_FALLING_BIT]);
        end
    end

    // ************************************************************
    // start and stop sequencing
    // ************************************************************
    assign sw_start = wr_lane0 & (aw_index_reg == `ASC_IDX_START_STATUS)
                    & w_data_reg[`ASC_START_RUN_BIT] & ~timer_busy;
    assign sw_stop  = wr_lane0 & (aw_index_reg == `ASC_IDX_START_STATUS)
                    & ~w_data_reg[`ASC_START_RUN_BIT];
    assign ext_edge = (trig_edge_reg == ASC_EDGE_FALLING) ? trig_fall : trig_rise;
    // a trigger during a running conversion is ignored, not queued
    assign ext_start = mode_reg[`ASC_MODE_TRIG_BIT] & ext_edge & ~timer_busy;

    asc_trigger_sync u_trigger_sync (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .trigger_pin (ext_trigger_pin),
        .rise_pulse  (trig_rise),
        .fall_pulse  (trig_fall)
    );

    // period select is sampled at the start only
    asc_conv_timer u_conv_timer (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .start        (sw_start | ext_start),
        .stop         (sw_stop),
        .period_short (mode_reg[`ASC_MODE_PERIOD_BIT]),
        .busy         (timer_busy),
        .done         (timer_done)
    );

    // one-cycle request to the analog front end to sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_start_reg <= 1'b0;
        end else begin
            sample_start_reg <= (sw_start | ext_start) & ~sw_stop;
        end
    end
    assign sample_start    = sample_start_reg;
    assign conversion_busy = timer_busy;

    // result only changes on a completed conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_result_reg <= `ASC_RESULT_RESET;
        end else if (timer_done) begin
            conversion_result_reg <= sample_data;
        end
    end

    // ************************************************************
    // channel decode
    // ************************************************************
    // upper bits 00 select nothing so the mux can be parked
    assign code_valid   = mode_reg[3] | mode_reg[2];
    assign input_number = mode_reg[3] ? {1'b0, mode_reg[2:0]} + 4'h4
                                      : {2'b00, mode_reg[1:0]};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_select
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    select_reg[gi] <= 1'b0;
                end else begin
                    select_reg[gi] <= code_valid & (input_number == 4'(gi));
                end
            end
        end
    endgenerate
    assign analog_input_select = select_reg;

    // ************************************************************
    // interrupt status
    // ************************************************************
    assign irq_events[`ASC_IRQ_DONE_BIT] = timer_done;
    assign irq_events[`ASC_IRQ_EXT_BIT]  = ext_start & ~sw_stop;
    assign irq_events[`ASC_IRQ_STOP_BIT] = sw_stop & timer_busy;

    // read clears, but a new event in the same cycle stays set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= '0;
        end else if (rd_take && rd_index == `ASC_IDX_IRQ_STATUS) begin
            irq_status_reg <= irq_events;
        end else begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end
    assign irq = |(irq_status_reg & irq_mask_reg);

    // ************************************************************
    // read channel
    // ************************************************************
    assign s_axi_arready = ~rvalid_reg;
    assign rd_take       = s_axi_arvalid & ~rvalid_reg;
    assign rd_index      = s_axi_araddr[11:2];

    always_comb begin
        rd_word   = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (rd_index)
            `ASC_IDX_MODE:         rd_word[7:0] = mode_reg;
            `ASC_IDX_RESULT:       rd_word[7:0] = conversion_result_reg;
            `ASC_IDX_START_STATUS: rd_word[7:0] = `ASC_START_FILL | {7'h00, timer_busy};
            `ASC_IDX_IRQ_STATUS:   rd_word[`ASC_IRQ_WIDTH-1:0] = irq_status_reg;
            `ASC_IDX_IRQ_MASK:     rd_word[`ASC_IRQ_WIDTH-1:0] = irq_mask_reg;
            `ASC_IDX_TRIG_CONFIG:  rd_word[0] = trig_edge_reg;
            default:               rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `ASC_RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_mapped ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
            rdata_reg  <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

endmodule
`default_nettype wire

/* logic/asc_conv_timer.sv */
// conversion period counter: runs one period per start, reports done
// assumes start and stop come from logic on aclk
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"
module asc_conv_timer
    import asc_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic start,
    input  wire logic stop,
    input  wire logic period_short,
    output logic      busy,
    output logic      done
);
    asc_count_type count_reg;
    logic          busy_reg;

    // stop beats completion in the same cycle, so no result is taken
    assign done = busy_reg & (count_reg == 6'h00) & ~stop;
    assign busy = busy_reg;

    // load period minus one, count to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_reg  <= 1'b0;
            count_reg <= 6'h00;
        end else if (stop || done) begin
            busy_reg  <= 1'b0;
            count_reg <= 6'h00;
        end else if (start && !busy_reg) begin
            busy_reg  <= 1'b1;
            count_reg <= period_short ? (`ASC_PERIOD_SHORT - 6'h01)
                                      : (`ASC_PERIOD_LONG - 6'h01);
        end else if (busy_reg) begin
            count_reg <= count_reg - 6'h01;
        end
    end
endmodule
`default_nettype wire

/* logic/asc_defines.svh */
// constants for the converter sequencing control: offsets, field positions,
// reset values and timing counts; included by asc_control, asc_conv_timer, the checker and the bench
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// ************************************************************
// register word indices (byte address is four times the index)
// ************************************************************
`define ASC_IDX_MODE          10'h0C4
`define ASC_IDX_RESULT        10'h0C5
`define ASC_IDX_START_STATUS  10'h0C6
`define ASC_IDX_IRQ_STATUS    10'h0C7
`define ASC_IDX_IRQ_MASK      10'h0C8
`define ASC_IDX_TRIG_CONFIG   10'h0C9

// ************************************************************
// field positions
// ************************************************************
`define ASC_MODE_PERIOD_BIT   7
`define ASC_MODE_TRIG_BIT     6
`define ASC_START_RUN_BIT     0
`define ASC_TRIG_FALLING_BIT  0
`define ASC_IRQ_DONE_BIT      0
`define ASC_IRQ_EXT_BIT       1
`define ASC_IRQ_STOP_BIT      2
`define ASC_IRQ_WIDTH         3

// ************************************************************
// reset values, mode write mask and fixed read values
// ************************************************************
`define ASC_MODE_RESET        8'h30
`define ASC_MODE_WR_MASK      8'hCF
`define ASC_START_FILL        8'hFE
`define ASC_RESULT_RESET      8'h00

// ************************************************************
// timing: conversion periods in system clock cycles, clock rate and minimum conversion time
// ************************************************************
`define ASC_PERIOD_LONG       6'h3E
`define ASC_PERIOD_SHORT      6'h1F
`define ASC_CLK_MHZ           100
`define ASC_MIN_CONV_TIME_NS  12400
`define ASC_MIN_CONV_CYCLES   ((`ASC_MIN_CONV_TIME_NS * `ASC_CLK_MHZ + 999) / 1000)

// ************************************************************
// bus answer codes
// ************************************************************
`define ASC_RESP_OKAY         2'h0
`define ASC_RESP_SLVERR       2'h2

`endif

/* logic/asc_pkg.sv */
// types shared by the converter sequencing control modules
// assumes asc_defines.svh sits on the include path
package asc_pkg;
    typedef logic [7:0] asc_byte_type;
    typedef logic [5:0] asc_count_type;
    typedef enum logic {ASC_EDGE_RISING, ASC_EDGE_FALLING} asc_edge_type;
endpackage

/* logic/asc_trigger_sync.sv */
// synchroniser and edge detector for the external trigger pin
// assumes the pin is asynchronous to aclk
`timescale 1ns/100ps
`default_nettype none
module asc_trigger_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic trigger_pin,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // two flops before anything looks at the pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= trigger_pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // edges seen only on the second and third flop
    assign rise_pulse = sync_reg & ~prev_reg;
    assign fall_pulse = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

/* sim/asc_control_sva.sv */
// checker for the converter sequencing control top: bus handshakes,
// conversion timing, channel decode
// assumes it is bound to asc_control and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"
module asc_control_sva
    import asc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int NUM_INPUTS = 12
) (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic                  sample_start,
    input wire logic                  conversion_busy,
    input wire logic [NUM_INPUTS-1:0] analog_input_select,
    input wire logic                  irq
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // busy run length; a counter because 62 is too long for a repetition
    logic [6:0] busy_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !conversion_busy) begin
            busy_cnt <= 7'h00;
        end else begin
            busy_cnt <= busy_cnt + 7'h01;
        end
    end

    busy_len_a: assert property (conversion_busy |-> busy_cnt < 7'h3E)
        else $error("conversion longer than 62 cycles");
    start_pulse_a: assert property ($rose(conversion_busy) |-> sample_start)
        else $error("no sample start at conversion start");
    pulse_cause_a: assert property (sample_start |-> $rose(conversion_busy))
        else $error("sample start without a new conversion");
    pulse_one_a: assert property (sample_start |=> !sample_start)
        else $error("sample start longer than one cycle");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    sel_onehot_a: assert property ($onehot0(analog_input_select))
        else $error("more than one input selected");
    result_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above the low byte");

    cover property ($fell(conversion_busy));
    cover property (s_axi_rvalid && s_axi_rresp == `ASC_RESP_SLVERR);
    cover property (irq);
endmodule

bind asc_control asc_control_sva #(.ADDR_WIDTH(ADDR_WIDTH), .NUM_INPUTS(NUM_INPUTS))
    u_asc_control_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_start(sample_start),
    .conversion_busy(conversion_busy), .analog_input_select(analog_input_select), .irq(irq));
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the converter sequencing control top
// assumes the register map and one-write, one-read bus timing of asc_control
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"
module tb
    import asc_pkg::*;
;
    localparam logic [11:0] A_MODE = {`ASC_IDX_MODE, 2'h0};
    localparam logic [11:0] A_RES  = {`ASC_IDX_RESULT, 2'h0};
    localparam logic [11:0] A_STAT = {`ASC_IDX_START_STATUS, 2'h0};
    localparam logic [11:0] A_IST  = {`ASC_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] A_MSK  = {`ASC_IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] A_TRG  = {`ASC_IDX_TRIG_CONFIG, 2'h0};
    localparam logic [1:0]  OK     = `ASC_RESP_OKAY;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata;
    logic awvalid, wvalid, bready, arvalid, rready, trig;
    logic [7:0] sample, v, res_old;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic awready, wready, bvalid, arready, rvalid, sample_start, busy, irq;
    wire logic [11:0] sel;
    int num_errors = 0, check_count = 0, run_cnt = 0, busy_len = 0, start_cnt = 0;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];

    asc_control u_asc_control (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trigger_pin(trig),
        .sample_data(sample), .sample_start(sample_start), .conversion_busy(busy),
        .analog_input_select(sel), .irq(irq));

    // ****************************************
    // clock, checking and bus tasks
    // ****************************************
    always #5 aclk = ~aclk;

    task automatic results;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // a wait that runs out ends the run as a failure
    task automatic timed_out;
        num_errors++;
        results();
    endtask

    // answers are compared in the order the requests were noted
    always @(posedge aclk) begin
        if (aresetn && rvalid && rready) begin
            check("rdata", rdata, {exp_r[0][33:2]});
            check("rresp", {30'h0, rresp}, {30'h0, exp_r[0][1:0]});
            void'(exp_r.pop_front());
        end
        if (aresetn && bvalid && bready) begin
            check("bresp", {30'h0, bresp}, {30'h0, exp_b[0]});
            void'(exp_b.pop_front());
        end
    end

    // length of each busy run and count of sample start pulses
    always @(posedge aclk) begin
        if (busy) begin
            run_cnt <= run_cnt + 1;
        end else if (run_cnt != 0) begin
            busy_len <= run_cnt;
            run_cnt <= 0;
        end
        if (sample_start) begin
            start_cnt <= start_cnt + 1;
        end
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = OK);
        int n;
        @(posedge aclk);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            n++;
        end while (!bvalid && n < 20);
        bready <= 1'h0;
        if (n == 20) timed_out();
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = OK);
        int n;
        @(posedge aclk);
        exp_r.push_back({24'h0, d, r});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            n++;
        end while (!rvalid && n < 20);
        rready <= 1'h0;
        if (n == 20) timed_out();
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 300) begin
            @(posedge aclk);
            n++;
        end
        if (n == 300) timed_out();
        @(posedge aclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, trig} = '0;
        sample = 8'h00;
        void'($urandom(63086));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(A_MODE, `ASC_MODE_RESET);
        rd(A_STAT, `ASC_START_FILL);
        rd(A_IST, 8'h00);
        // every channel code, random period bit, trigger kept off
        for (int i = 0; i < 16; i++) begin
            v = (8'($urandom) & 8'hB0) | 8'(i);
            wr(A_MODE, v);
            rd(A_MODE, v | 8'h30);
            check("select", {20'h0, sel}, i[3] ? 32'h10 << i[2:0] :
                (i[2] ? 32'h1 << i[1:0] : 32'h0));
        end
        // long then short period, second start while busy is ignored
        wr(A_MSK, 8'h07);
        for (int k = 0; k < 2; k++) begin
            sample <= 8'($urandom);
            wr(A_MODE, k ? 8'h80 : 8'h00); // time floor is software's, unchecked
            wr(A_STAT, 8'h01);
            rd(A_STAT, 8'hFF);
            wr(A_STAT, 8'h01);
            wait_busy(1'h0);
            rd(A_RES, sample);
            check("period", busy_len, k ? 31 : 62);
            check("irq", {31'h0, irq}, 32'h1);
            rd(A_IST, 8'h01);
            check("irq", {31'h0, irq}, 32'h0);
        end
        check("pulses", start_cnt, 2);
        // software stop keeps the old result
        res_old = sample;
        sample <= ~sample;
        wr(A_MODE, 8'h00);
        wr(A_STAT, 8'h01);
        repeat (5) @(posedge aclk);
        wr(A_STAT, 8'h00);
        wait_busy(1'h0);
        rd(A_STAT, `ASC_START_FILL);
        rd(A_RES, res_old);
        rd(A_IST, 8'h04);
        // external trigger on rising, then falling, then disabled
        wr(A_TRG, 8'h00);
        wr(A_MODE, 8'hC0);
        trig <= 1'h1;
        wait_busy(1'h1);
        wait_busy(1'h0);
        rd(A_IST, 8'h03);
        wr(A_TRG, 8'h01);
        trig <= 1'h0;
        wait_busy(1'h1);
        wait_busy(1'h0);
        rd(A_IST, 8'h03);
        // falling edge is still selected, so only the enable bit can block it
        wr(A_MODE, 8'h80);
        trig <= 1'h1;
        repeat (5) @(posedge aclk);
        trig <= 1'h0;
        repeat (10) @(posedge aclk);
        check("busy", {31'h0, busy}, 32'h0);
        rd(A_IST, 8'h00);
        // unmapped place and read-only result
        rd(12'h400, 8'h00, `ASC_RESP_SLVERR);
        wr(12'h400, 8'h55, `ASC_RESP_SLVERR);
        wr(A_RES, ~sample);
        rd(A_RES, sample);
        results();
    end
endmodule
`default_nettype wire
